// ### shared/ldc_pkg.sv
`default_nettype none
package ldc_pkg;
	// Byte addresses; printed offsets are not all multiples of four
	localparam logic [15:0] IDX_POWER   = 16'hff03;
	localparam logic [15:0] IDX_MODE    = 16'hff10;
	localparam logic [15:0] IDX_DISPLAY = 16'hff11;
	localparam int          ADDR_W      = 18;
	localparam logic [17:0] ADDR_POWER   = {IDX_POWER, 2'b00};
	localparam logic [17:0] ADDR_MODE    = {IDX_MODE, 2'b00};
	localparam logic [17:0] ADDR_DISPLAY = {IDX_DISPLAY, 2'b00};

	// Field positions
	localparam int POS_BOOSTER   = 0;
	localparam int POS_REG_SUP   = 1;
	localparam int POS_DUTY      = 0;
	localparam int POS_FONT      = 2;
	localparam int POS_RSVD      = 3;
	localparam int POS_SEGMENT_REVERSE    = 6;
	localparam int POS_HEAVY     = 7;
	localparam int POS_CONTRAST  = 0;
	localparam int POS_DMODE     = 4;
	localparam int POS_AREA      = 6;
	localparam int POS_FRAME     = 7;

	// Reset values
	localparam logic [7:0] RST_POWER   = 8'h00;
	localparam logic [7:0] RST_MODE    = 8'h02;
	localparam logic [7:0] RST_DISPLAY = 8'h00;
	localparam logic [7:0] MASK_POWER  = 8'h03;

	// Display-mode codes
	localparam logic [1:0] DMODE_OFF    = 2'h0;
	localparam logic [1:0] DMODE_NORMAL = 2'h1;
	localparam logic [1:0] DMODE_DARK   = 2'h2;
	localparam logic [1:0] DMODE_LIT    = 2'h3;

	// Duty codes
	localparam logic [1:0] DUTY_8  = 2'h0;
	localparam logic [1:0] DUTY_32 = 2'h1;
	localparam logic [1:0] DUTY_16 = 2'h2;
	localparam logic [1:0] DUTY_BAD = 2'h3;
	localparam logic [5:0] COMS_8  = 6'h08;
	localparam logic [5:0] COMS_16 = 6'h10;
	localparam logic [5:0] COMS_32 = 6'h20;

	typedef enum logic [1:0] {
		LDC_DRV_OFF,
		LDC_DRV_NORMAL,
		LDC_DRV_DARK,
		LDC_DRV_LIT
	} ldc_drive_t;

	typedef struct packed {
		logic        drive_enable;
		logic        blank_dynamic;
		logic        static_common;
		logic        lcd_power_on;
		logic [5:0]  common_count;
		logic        font_layout_sel;
		logic        segment_reverse;
		logic        display_area_sel;
		logic        frame_clock_sel;
		logic [3:0]  contrast_code;
		logic        heavy_load_mode;
	} ldc_drive_ctl_t;

	typedef struct packed {
		logic booster_on;
		logic regulator_supply_sel;
	} ldc_supply_ctl_t;
endpackage
`default_nettype wire

// ### rtl/ldc_ctrl.sv
// Operation
// [R1] Mode field 11 lit, 10 dark, 01 normal, 00 drive off.
// [R2] All-on and all-off affect drive waveform only, never display memory.
// [R3] All-on drives commons statically; all-off keeps multiplexed common drive.
// [R4] Drive-off turns LCD power circuit off, bias levels to ground.
// [R5] Sleep and reset clear mode field to drive off.
// [R6] Four-bit contrast, 16 steps, ones darkest, resets to zero.
// [R7] Duty 10 gives 1/16, 01 1/32, 00 1/8; 11 illegal; reset 10.
// [R8] Font bit one selects 12x12 layout, zero 16x16 or 5x8.
// [R9] Segment-reverse bit mirrors column-to-segment order; resets normal.
// [R10] Area bit selects display memory area 0 or 1; resets 0.
// [R11] Frame clock from low-speed oscillator when zero, timer 5 when one.
// [R12] Booster bit turns voltage doubler on when one; resets off.
// [R13] Regulator supply bit picks boosted supply when one; resets main.
// [R14] Software enables booster and waits 1 ms before boosted supply.
// [R15] Software should keep booster off while regulator uses main supply.
// [R16] Upper power bits read zero; three reserved mode bits are storage.
`default_nettype none
module ldc_ctrl (
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     reset,
	// Avalon-MM slave
	input  wire logic [17:0]              avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [31:0]              avs_writedata,
	input  wire logic [3:0]               avs_byteenable,
	output logic      [31:0]              avs_readdata,
	output logic                          avs_waitrequest,
	output logic      [1:0]               avs_response,
	// System events
	input  wire logic                     sleep_instruction,
	// Drive side
	output ldc_pkg::ldc_drive_ctl_t       drive_ctl,
	output ldc_pkg::ldc_supply_ctl_t      supply_ctl
);
	logic [7:0]  power_r, power_nxt;
	logic [7:0]  mode_r, mode_nxt;
	logic [7:0]  display_r, display_nxt;
	logic        ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  resp_r, resp_nxt;
	logic        hit;
	logic [7:0]  rd_byte;

	function automatic logic [5:0] duty_commons(input logic [1:0] duty);
		unique case (duty)
			ldc_pkg::DUTY_8:  duty_commons = ldc_pkg::COMS_8;
			ldc_pkg::DUTY_32: duty_commons = ldc_pkg::COMS_32;
			ldc_pkg::DUTY_16: duty_commons = ldc_pkg::COMS_16;
			default:          duty_commons = 6'h00;
		endcase
	endfunction

	// One wait cycle per access, answer registered
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata    = rdata_r;
	assign avs_response    = resp_r;

	always_comb begin
		hit = 1'b1;
		rd_byte = 8'h00;
		unique case (avs_address)
			// [R16] Unused power bits zero
			ldc_pkg::ADDR_POWER:   rd_byte = power_r & ldc_pkg::MASK_POWER;
			ldc_pkg::ADDR_MODE:    rd_byte = mode_r;
			ldc_pkg::ADDR_DISPLAY: rd_byte = display_r;
			default:               hit = 1'b0;
		endcase
	end

	always_comb begin
		power_nxt   = power_r;
		mode_nxt    = mode_r;
		display_nxt = display_r;
		ack_nxt     = (avs_read | avs_write) & ~ack_r;
		rdata_nxt   = rdata_r;
		resp_nxt    = resp_r;
		if ((avs_read | avs_write) & ~ack_r) begin
			resp_nxt  = hit ? 2'h0 : 2'h3;
			rdata_nxt = avs_read ? {24'h000000, rd_byte} : 32'h00000000;
		end
		if (avs_write & ~ack_r & avs_byteenable[0]) begin
			unique case (avs_address)
				// [R12] Booster and [R13] supply select
				ldc_pkg::ADDR_POWER: power_nxt = avs_writedata[7:0] & ldc_pkg::MASK_POWER;
				// [R7] Duty, font, reverse, reserved storage [R16]
				ldc_pkg::ADDR_MODE: mode_nxt = avs_writedata[7:0];
				// [R6] Contrast, mode, area, frame clock
				ldc_pkg::ADDR_DISPLAY: display_nxt = avs_writedata[7:0];
				default: begin
				end
			endcase
		end
		// [R5] Sleep forces drive off, wins over a write
		if (sleep_instruction) begin
			display_nxt[ldc_pkg::POS_DMODE +: 2] = ldc_pkg::DMODE_OFF;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			// [R5] Reset to drive off, duty 1/16
			power_r   <= ldc_pkg::RST_POWER;
			mode_r    <= ldc_pkg::RST_MODE;
			display_r <= ldc_pkg::RST_DISPLAY;
			ack_r     <= 1'b0;
			rdata_r   <= 32'h00000000;
			resp_r    <= 2'h0;
		end else begin
			power_r   <= power_nxt;
			mode_r    <= mode_nxt;
			display_r <= display_nxt;
			ack_r     <= ack_nxt;
			rdata_r   <= rdata_nxt;
			resp_r    <= resp_nxt;
		end
	end

	ldc_pkg::ldc_drive_t drive_mode;
	assign drive_mode = ldc_pkg::ldc_drive_t'(display_r[ldc_pkg::POS_DMODE +: 2]);

	always_comb begin
		// [R1] Mode decode
		drive_ctl.drive_enable  = (drive_mode != ldc_pkg::LDC_DRV_OFF);
		// [R2] Blanking acts on waveform, memory untouched
		drive_ctl.blank_dynamic = (drive_mode == ldc_pkg::LDC_DRV_DARK);
		// [R3] Static commons only when all lit
		drive_ctl.static_common = (drive_mode == ldc_pkg::LDC_DRV_LIT);
		// [R4] Power circuit off grounds bias levels
		drive_ctl.lcd_power_on  = (drive_mode != ldc_pkg::LDC_DRV_OFF);
		// [R7] Illegal duty yields zero commons
		drive_ctl.common_count  = duty_commons(mode_r[ldc_pkg::POS_DUTY +: 2]);
		// [R8] Font layout
		drive_ctl.font_layout_sel  = mode_r[ldc_pkg::POS_FONT];
		// [R9] Segment mirror
		drive_ctl.segment_reverse  = mode_r[ldc_pkg::POS_SEGMENT_REVERSE];
		// [R10] Area select
		drive_ctl.display_area_sel = display_r[ldc_pkg::POS_AREA];
		// [R11] Frame clock source
		drive_ctl.frame_clock_sel  = display_r[ldc_pkg::POS_FRAME];
		// [R6] Contrast code
		drive_ctl.contrast_code    = display_r[ldc_pkg::POS_CONTRAST +: 4];
		drive_ctl.heavy_load_mode  = mode_r[ldc_pkg::POS_HEAVY];
		// [R12] Doubler, [R13] regulator supply
		supply_ctl.booster_on           = power_r[ldc_pkg::POS_BOOSTER];
		supply_ctl.regulator_supply_sel = power_r[ldc_pkg::POS_REG_SUP];
	end

	// [R5] Sleep clears mode next cycle
	chk_sleep_clears_mode: assert property (@(posedge ref_clk) disable iff (reset)
		sleep_instruction |=> display_r[5:4] == 2'h0) else $error("sleep did not clear mode");
	// [R3] Static commons only in lit mode
	chk_static_lit: assert property (@(posedge ref_clk) disable iff (reset)
		drive_ctl.static_common |-> display_r[5:4] == 2'h3) else $error("static wrong");
	// [R4] Off mode powers down
	chk_off_power: assert property (@(posedge ref_clk) disable iff (reset)
		display_r[5:4] == 2'h0 |-> !drive_ctl.lcd_power_on) else $error("power on in off");
	// [R16] Upper power bits zero
	chk_power_upper: assert property (@(posedge ref_clk) disable iff (reset)
		power_r[7:2] == 6'h00) else $error("power upper bits set");
	// [R7] Duty 1/16 gives 16 commons
	chk_duty_count: assert property (@(posedge ref_clk) disable iff (reset)
		mode_r[1:0] == 2'h2 |-> drive_ctl.common_count == 6'h10) else $error("duty count");
	// [R6] Contrast follows write
	chk_contrast_wr: assert property (@(posedge ref_clk) disable iff (reset)
		avs_write && !ack_r && avs_byteenable[0] && avs_address == ldc_pkg::ADDR_DISPLAY
		|=> drive_ctl.contrast_code == $past(avs_writedata[3:0])) else $error("contrast");
	// [R9] Reverse set when mode bit 6 rises
	chk_seg_reverse: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(mode_r[6]) |-> drive_ctl.segment_reverse) else $error("segment_reverse");
	// [R12] Booster follows write
	chk_booster_wr: assert property (@(posedge ref_clk) disable iff (reset)
		avs_write && !ack_r && avs_byteenable[0] && avs_address == ldc_pkg::ADDR_POWER
		|=> supply_ctl.booster_on == $past(avs_writedata[0])) else $error("booster");
	// Bus answer in one cycle
	chk_bus_answer: assert property (@(posedge ref_clk) disable iff (reset)
		(avs_read || avs_write) && !ack_r |=> !avs_waitrequest) else $error("no answer");
endmodule
`default_nettype wire

// ### sim/ldc_panel_model.sv
`default_nettype none
module ldc_panel_model (
	// Drive controls
	input  wire ldc_pkg::ldc_drive_ctl_t  drive_ctl,
	input  wire ldc_pkg::ldc_supply_ctl_t supply_ctl,
	// Panel view
	output logic [5:0]                    lit_commons
);
	timeunit 1ns;
	timeprecision 100ps;
	// static one common, drive-off panel unpowered
	assign lit_commons = !drive_ctl.lcd_power_on ? 6'h00 :
		drive_ctl.static_common ? 6'h01 : drive_ctl.common_count;
endmodule
`default_nettype wire

// ### sim/lcd_driver_control_tb.sv
`default_nettype none
module lcd_driver_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                     ref_clk;
	logic                     reset;
	logic [17:0]              avs_address;
	logic                     avs_read;
	logic                     avs_write;
	logic [31:0]              avs_writedata;
	logic [31:0]              avs_readdata;
	logic                     avs_waitrequest;
	logic [1:0]               avs_response;
	logic                     sleep_instruction;
	ldc_pkg::ldc_drive_ctl_t  drive_ctl;
	ldc_pkg::ldc_supply_ctl_t supply_ctl;
	logic [5:0]               lit_commons;
	logic [33:0]              rsp;
	logic [5:0]               coms [4] = '{6'h08, 6'h20, 6'h10, 6'h00};
	int                       miscompares = 0;
	int                       checks = 0;
	int                       cyc = 0;

	ldc_ctrl dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.sleep_instruction(sleep_instruction), .drive_ctl(drive_ctl),
		.supply_ctl(supply_ctl));
	ldc_panel_model panel (.drive_ctl(drive_ctl), .supply_ctl(supply_ctl),
		.lit_commons(lit_commons));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic end_of_test();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard; the booster wait alone is 40000 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [17:0] a, input logic [7:0] d);
		int n;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++n < 20);
		rsp = {avs_response, avs_readdata};
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rdc(input logic [17:0] a, input logic [7:0] e, input logic [1:0] r);
		acc(1'b0, a, 8'h00);
		chk(rsp, {r, 24'h0, e});
	endtask

	task automatic rst_chk();
		rdc(ldc_pkg::ADDR_POWER, 8'h00, 2'b00);
		rdc(ldc_pkg::ADDR_MODE, 8'h02, 2'b00);
		rdc(ldc_pkg::ADDR_DISPLAY, 8'h00, 2'b00);
	endtask

	initial begin
		reset = 1'b1;
		avs_address = 18'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		sleep_instruction = 1'b0;
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rst_chk();
		for (int m = 0; m < 4; m++) begin
			acc(1'b1, ldc_pkg::ADDR_DISPLAY, {2'b11, m[1:0], 4'hf});
			chk({drive_ctl.static_common, drive_ctl.blank_dynamic, drive_ctl.lcd_power_on,
				drive_ctl.drive_enable}, {m == 3, m == 2, m != 0, m != 0});
			chk(lit_commons, m == 0 ? 6'h00 : m == 3 ? 6'h01 : 6'h10);
			chk({drive_ctl.frame_clock_sel, drive_ctl.display_area_sel,
				drive_ctl.contrast_code}, 6'h3f);
		end
		for (int d = 0; d < 4; d++) begin
			acc(1'b1, ldc_pkg::ADDR_MODE, 8'hfc | d[7:0]);
			chk({drive_ctl.common_count, drive_ctl.font_layout_sel,
				drive_ctl.segment_reverse, drive_ctl.heavy_load_mode},
				{coms[d], 3'b111});
			rdc(ldc_pkg::ADDR_MODE, 8'hfc | d[7:0], 2'b00);
		end
		acc(1'b1, ldc_pkg::ADDR_POWER, 8'h01);
		chk(supply_ctl, 2'b10);
		repeat (40000) @(posedge ref_clk);
		acc(1'b1, ldc_pkg::ADDR_POWER, 8'hff);
		chk(supply_ctl, 2'b11);
		rdc(ldc_pkg::ADDR_POWER, 8'h03, 2'b00);
		acc(1'b1, ldc_pkg::ADDR_POWER, 8'h00);
		acc(1'b1, ldc_pkg::ADDR_DISPLAY, 8'h3a);
		sleep_instruction <= 1'b1;
		@(posedge ref_clk);
		sleep_instruction <= 1'b0;
		@(posedge ref_clk);
		rdc(ldc_pkg::ADDR_DISPLAY, 8'h0a, 2'b00);
		rdc(18'h3fc10, 8'h00, 2'b11);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rst_chk();
		end_of_test();
	end
endmodule
`default_nettype wire
